// *** rtl/jle_pkg.sv ***
// constants, types and state layout for the jump/load execution slice
// assumes an 8-bit register file and a 16-bit program memory space
package jle_pkg;
    localparam logic [3:0]  WREG_NIB = 4'he;   // operand nibble: working reg
    localparam logic [7:0]  IMR_ADDR = 8'hfb;  // interrupt_mask_reg address
    localparam logic [7:0]  IMR_RST  = 8'h00;
    localparam logic [15:0] PC_RST   = 16'h0000;
    // opcode low nibbles for the per-register / per-condition forms
    localparam logic [3:0]  NIB_JPCC = 4'hd;
    localparam logic [3:0]  NIB_JR   = 4'hb;
    localparam logic [3:0]  NIB_LDIM = 4'hc;
    localparam logic [3:0]  NIB_LDR8 = 4'h8;
    localparam logic [3:0]  NIB_LDR9 = 4'h9;
    // full opcodes
    localparam logic [7:0]  OP_JPIND = 8'h30;
    localparam logic [7:0]  OP_E3    = 8'he3;
    localparam logic [7:0]  OP_F3    = 8'hf3;
    localparam logic [7:0]  OP_E4    = 8'he4;
    localparam logic [7:0]  OP_E5    = 8'he5;
    localparam logic [7:0]  OP_E6    = 8'he6;
    localparam logic [7:0]  OP_E7    = 8'he7;
    localparam logic [7:0]  OP_F5    = 8'hf5;
    localparam logic [7:0]  OP_C7    = 8'hc7;
    localparam logic [7:0]  OP_D7    = 8'hd7;
    localparam logic [7:0]  OP_C2    = 8'hc2;
    localparam logic [7:0]  OP_D2    = 8'hd2;
    // instruction lengths in core cycles
    localparam logic [3:0]  CYC_TAKEN = 4'd12;
    localparam logic [3:0]  CYC_NOTTK = 4'd10;
    localparam logic [3:0]  CYC_JPIND = 4'd8;
    localparam logic [3:0]  CYC_SHORT = 4'd6;
    localparam logic [3:0]  CYC_LONG  = 4'd10;
    localparam logic [3:0]  CYC_LDC   = 4'd12;

    // gray coded along opc-b1-b2-ptr-ptrlo-data-write-pad
    typedef enum logic [2:0] {
        ST_OPC = 3'h0, ST_B1 = 3'h1, ST_B2 = 3'h3, ST_PTR = 3'h2,
        ST_PTRLO = 3'h6, ST_DATA = 3'h7, ST_WRITE = 3'h5, ST_PAD = 3'h4
    } state_e;

    typedef enum logic [4:0] {
        CL_BAD, CL_JPCC, CL_JPIND, CL_JR, CL_LDIM, CL_R8, CL_R9,
        CL_E3, CL_F3, CL_E4, CL_E5, CL_E6, CL_E7, CL_F5, CL_C7, CL_D7,
        CL_C2, CL_D2
    } cls_e;

    typedef struct packed {
        logic c; logic z; logic s; logic v; logic d; logic h;
    } flags_s;

    typedef struct packed {
        logic        we;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pmReq_s;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rfReq_s;

    typedef struct packed {
        state_e      st;
        cls_e        cls;
        logic [7:0]  op;
        logic [7:0]  b1;
        logic [7:0]  b2;
        logic [7:0]  ptr;
        logic [15:0] ptr16;
        logic [7:0]  data;
        logic [3:0]  cnt;
        logic        taken;
        logic [15:0] pc;
        logic [7:0]  interrupt_mask_reg;
        rfReq_s      rfw;
        pmReq_s      pmw;
        logic        done;
        logic        bad;
    } core_s;
endpackage : jle_pkg

// *** rtl/jump_load_exec_unit.sv ***
// jump, relative jump, register load and constant load execution slice
// assumes combinational read data from program memory and register file
// for the address driven in the same cycle; writes land one cycle later
`timescale 1ns/1ps

// Function
// - conditional direct jump loads 16-bit target if true
// - conditional jumps take 12 taken, 10 not
// - indirect jump loads pc from register pair, 8 cycles
// - pointer nibble E selects working register pair
// - relative jump adds displacement when condition holds
// - displacement is signed 8-bit, +127 to -128
// - displacement added to address after instruction
// - loads copy source to destination, source untouched
// - operand nibble E selects working register
// - immediate load target from opcode high nibble
// - E4/E5 take source byte before destination byte
// - indexed address is base plus index register
// - write to FBh updates interrupt mask directly
// - constant load moves byte, 12 cycles
// - constant address from working pair, pair unchanged
module jump_load_exec_unit (
    input  wire logic            ref_clk,
    input  wire logic            rst_b,
    input  wire logic [3:0]      wrkPtr,
    input  jle_pkg::flags_s      flags,
    output logic      [15:0]     pmemAddr,
    input  wire logic [7:0]      pmemRdata,
    output logic                 pmemWe,
    output logic      [7:0]      pmemWdata,
    output logic      [7:0]      rfAddr,
    input  wire logic [7:0]      rfRdata,
    output logic                 rfWe,
    output logic      [7:0]      rfWdata,
    output logic      [15:0]     pc,
    output logic      [7:0]      intMask,
    output logic                 instrDone,
    output logic                 illegalOp
);
    jle_pkg::core_s q_ff;
    jle_pkg::core_s nxt_q;

    // operand byte to register address, E-nibble means working register
    function automatic logic [7:0] regAddr(input logic [7:0] b);
        if (b[7:4] == jle_pkg::WREG_NIB) begin
            regAddr = {wrkPtr, b[3:0]};
        end else begin
            regAddr = b;
        end
    endfunction : regAddr

    function automatic logic [7:0] wr(input logic [3:0] n);
        wr = {wrkPtr, n};
    endfunction : wr

    // flags are only read here, never written by this slice
    function automatic logic condTrue(input logic [3:0] cc);
        logic b;
        b = 1'b0;
        case (cc[2:0])
            3'h0: b = 1'b0;
            3'h1: b = flags.s ^ flags.v;
            3'h2: b = flags.z | (flags.s ^ flags.v);
            3'h3: b = flags.c | flags.z;
            3'h4: b = flags.v;
            3'h5: b = flags.s;
            3'h6: b = flags.z;
            default: b = flags.c;
        endcase
        condTrue = b ^ cc[3]; // upper half is the inverse test
    endfunction : condTrue

    function automatic jle_pkg::cls_e classify(input logic [7:0] o);
        classify = jle_pkg::CL_BAD;
        if (o[3:0] == jle_pkg::NIB_JPCC) begin
            classify = jle_pkg::CL_JPCC;
        end else if (o[3:0] == jle_pkg::NIB_JR) begin
            classify = jle_pkg::CL_JR;
        end else if (o[3:0] == jle_pkg::NIB_LDIM) begin
            classify = jle_pkg::CL_LDIM;
        end else if (o[3:0] == jle_pkg::NIB_LDR8) begin
            classify = jle_pkg::CL_R8;
        end else if (o[3:0] == jle_pkg::NIB_LDR9) begin
            classify = jle_pkg::CL_R9;
        end else if (o == jle_pkg::OP_JPIND) begin
            classify = jle_pkg::CL_JPIND;
        end else if (o == jle_pkg::OP_E3) begin
            classify = jle_pkg::CL_E3;
        end else if (o == jle_pkg::OP_F3) begin
            classify = jle_pkg::CL_F3;
        end else if (o == jle_pkg::OP_E4) begin
            classify = jle_pkg::CL_E4;
        end else if (o == jle_pkg::OP_E5) begin
            classify = jle_pkg::CL_E5;
        end else if (o == jle_pkg::OP_E6) begin
            classify = jle_pkg::CL_E6;
        end else if (o == jle_pkg::OP_E7) begin
            classify = jle_pkg::CL_E7;
        end else if (o == jle_pkg::OP_F5) begin
            classify = jle_pkg::CL_F5;
        end else if (o == jle_pkg::OP_C7) begin
            classify = jle_pkg::CL_C7;
        end else if (o == jle_pkg::OP_D7) begin
            classify = jle_pkg::CL_D7;
        end else if (o == jle_pkg::OP_C2) begin
            classify = jle_pkg::CL_C2;
        end else if (o == jle_pkg::OP_D2) begin
            classify = jle_pkg::CL_D2;
        end
    endfunction : classify

    // per-class sequencing properties
    logic       twoB;
    logic       needPtr;
    logic       isPair;
    logic       needData;
    logic [3:0] cost;
    logic [7:0] ptrAddr;
    logic [7:0] srcAddr;
    logic [7:0] disp;

    always_comb begin
        twoB = 1'b0; needPtr = 1'b0; isPair = 1'b0; needData = 1'b1;
        cost = jle_pkg::CYC_LONG; ptrAddr = wr(q_ff.b1[3:0]);
        srcAddr = regAddr(q_ff.b1);
        case (q_ff.cls)
            jle_pkg::CL_JPCC, jle_pkg::CL_JR: begin
                twoB = (q_ff.cls == jle_pkg::CL_JPCC); needData = 1'b0;
                cost = q_ff.taken ? jle_pkg::CYC_TAKEN
                                  : jle_pkg::CYC_NOTTK;
            end
            jle_pkg::CL_JPIND: begin
                needPtr = 1'b1; isPair = 1'b1; needData = 1'b0;
                ptrAddr = regAddr(q_ff.b1); cost = jle_pkg::CYC_JPIND;
            end
            jle_pkg::CL_LDIM, jle_pkg::CL_BAD: begin
                needData = 1'b0; cost = jle_pkg::CYC_SHORT;
            end
            jle_pkg::CL_R8: cost = jle_pkg::CYC_SHORT;
            jle_pkg::CL_R9: begin
                cost = jle_pkg::CYC_SHORT; srcAddr = wr(q_ff.op[7:4]);
            end
            jle_pkg::CL_E3: begin
                needPtr = 1'b1; cost = jle_pkg::CYC_SHORT;
                srcAddr = q_ff.ptr;
            end
            jle_pkg::CL_F3: begin
                needPtr = 1'b1; cost = jle_pkg::CYC_SHORT;
                ptrAddr = wr(q_ff.b1[7:4]); srcAddr = wr(q_ff.b1[3:0]);
            end
            jle_pkg::CL_E4: twoB = 1'b1;
            jle_pkg::CL_E5: begin
                twoB = 1'b1; needPtr = 1'b1;
                ptrAddr = regAddr(q_ff.b1); srcAddr = q_ff.ptr;
            end
            jle_pkg::CL_E6: begin
                twoB = 1'b1; needData = 1'b0;
            end
            jle_pkg::CL_E7: begin
                twoB = 1'b1; needPtr = 1'b1; needData = 1'b0;
                ptrAddr = regAddr(q_ff.b1);
            end
            jle_pkg::CL_F5: begin
                twoB = 1'b1; needPtr = 1'b1; ptrAddr = regAddr(q_ff.b2);
            end
            jle_pkg::CL_C7: begin
                twoB = 1'b1; needPtr = 1'b1; srcAddr = q_ff.ptr;
            end
            jle_pkg::CL_D7: begin
                twoB = 1'b1; needPtr = 1'b1; srcAddr = wr(q_ff.b1[7:4]);
            end
            default: begin // constant loads, pair named by low nibble
                needPtr = 1'b1; isPair = 1'b1; cost = jle_pkg::CYC_LDC;
                srcAddr = wr(q_ff.b1[7:4]);
            end
        endcase
    end

    // sign extension keeps the reach at +127..-128
    assign disp = q_ff.b1;

    // next-state of the whole core
    always_comb begin
        nxt_q = q_ff;
        nxt_q.cnt = q_ff.cnt + 4'h1;
        nxt_q.done = 1'b0;
        nxt_q.bad = 1'b0;
        nxt_q.rfw.we = 1'b0;
        nxt_q.pmw.we = 1'b0;
        if (q_ff.rfw.we && q_ff.rfw.addr == jle_pkg::IMR_ADDR) begin
            nxt_q.interrupt_mask_reg = q_ff.rfw.wdata;
        end
        case (q_ff.st)
            jle_pkg::ST_OPC: begin
                nxt_q.op = pmemRdata;
                nxt_q.cls = classify(pmemRdata);
                nxt_q.pc = q_ff.pc + 16'h1;
                nxt_q.taken = 1'b0;
                nxt_q.cnt = 4'h1;
                nxt_q.st = jle_pkg::ST_B1;
                if (classify(pmemRdata) == jle_pkg::CL_BAD) begin
                    nxt_q.bad = 1'b1;
                    nxt_q.st = jle_pkg::ST_PAD;
                end
            end
            jle_pkg::ST_B1, jle_pkg::ST_B2: begin
                if (q_ff.st == jle_pkg::ST_B1) begin
                    nxt_q.b1 = pmemRdata;
                end else begin
                    nxt_q.b2 = pmemRdata;
                end
                nxt_q.pc = q_ff.pc + 16'h1;
                if (q_ff.st == jle_pkg::ST_B1 && twoB) begin
                    nxt_q.st = jle_pkg::ST_B2;
                end else if (needPtr) begin
                    nxt_q.st = jle_pkg::ST_PTR;
                end else begin
                    nxt_q.st = needData ? jle_pkg::ST_DATA
                                        : jle_pkg::ST_WRITE;
                end
            end
            jle_pkg::ST_PTR: begin
                nxt_q.ptr = rfRdata;
                if (q_ff.cls == jle_pkg::CL_C7 ||
                    q_ff.cls == jle_pkg::CL_D7) begin
                    nxt_q.ptr = q_ff.b2 + rfRdata;
                end
                nxt_q.ptr16[15:8] = rfRdata;
                if (isPair) begin
                    nxt_q.st = jle_pkg::ST_PTRLO;
                end else begin
                    nxt_q.st = needData ? jle_pkg::ST_DATA
                                        : jle_pkg::ST_WRITE;
                end
            end
            jle_pkg::ST_PTRLO: begin
                nxt_q.ptr16[7:0] = rfRdata;
                nxt_q.st = needData ? jle_pkg::ST_DATA : jle_pkg::ST_WRITE;
            end
            jle_pkg::ST_DATA: begin
                nxt_q.data = (q_ff.cls == jle_pkg::CL_C2) ? pmemRdata
                                                          : rfRdata;
                nxt_q.st = jle_pkg::ST_WRITE;
            end
            jle_pkg::ST_WRITE: begin
                nxt_q.st = jle_pkg::ST_PAD;
                nxt_q.rfw.we = 1'b1; // only the destination is written
                nxt_q.rfw.wdata = q_ff.data;
                nxt_q.rfw.addr = q_ff.ptr;
                case (q_ff.cls)
                    jle_pkg::CL_JPCC: begin
                        nxt_q.rfw.we = 1'b0;
                        nxt_q.taken = condTrue(q_ff.op[7:4]);
                        if (condTrue(q_ff.op[7:4])) begin
                            nxt_q.pc = {q_ff.b1, q_ff.b2};
                        end
                    end
                    jle_pkg::CL_JR: begin
                        nxt_q.rfw.we = 1'b0;
                        nxt_q.taken = condTrue(q_ff.op[7:4]);
                        if (condTrue(q_ff.op[7:4])) begin
                            nxt_q.pc = q_ff.pc
                                     + {{8{disp[7]}}, disp};
                        end
                    end
                    jle_pkg::CL_JPIND: begin
                        nxt_q.rfw.we = 1'b0;
                        nxt_q.pc = q_ff.ptr16;
                    end
                    jle_pkg::CL_LDIM: begin
                        nxt_q.rfw.addr = wr(q_ff.op[7:4]);
                        nxt_q.rfw.wdata = q_ff.b1;
                    end
                    jle_pkg::CL_R8: nxt_q.rfw.addr = wr(q_ff.op[7:4]);
                    jle_pkg::CL_R9, jle_pkg::CL_E6: begin
                        nxt_q.rfw.addr = regAddr(q_ff.b1);
                        if (q_ff.cls == jle_pkg::CL_E6) begin
                            nxt_q.rfw.wdata = q_ff.b2;
                        end
                    end
                    jle_pkg::CL_E3, jle_pkg::CL_C7, jle_pkg::CL_C2:
                        nxt_q.rfw.addr = wr(q_ff.b1[7:4]);
                    jle_pkg::CL_E4, jle_pkg::CL_E5:
                        nxt_q.rfw.addr = regAddr(q_ff.b2);
                    jle_pkg::CL_E7: nxt_q.rfw.wdata = q_ff.b2;
                    jle_pkg::CL_D2: begin
                        nxt_q.rfw.we = 1'b0;
                        nxt_q.pmw.we = 1'b1;
                        nxt_q.pmw.addr = q_ff.ptr16;
                        nxt_q.pmw.wdata = q_ff.data;
                    end
                    default: begin
                    end
                endcase
            end
            default: begin
                if (q_ff.cnt == cost - 4'h1) begin
                    nxt_q.done = 1'b1;
                    nxt_q.cnt = 4'h0;
                    nxt_q.st = jle_pkg::ST_OPC;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            q_ff <= '0;
            q_ff.pc <= jle_pkg::PC_RST;
            q_ff.interrupt_mask_reg <= jle_pkg::IMR_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // a pending write owns the address lines for its cycle
    always_comb begin
        rfAddr = srcAddr;
        if (q_ff.rfw.we) begin
            rfAddr = q_ff.rfw.addr;
        end else if (q_ff.st == jle_pkg::ST_PTR) begin
            rfAddr = ptrAddr;
        end else if (q_ff.st == jle_pkg::ST_PTRLO) begin
            rfAddr = ptrAddr + 8'h1;
        end
        pmemAddr = q_ff.pc;
        if (q_ff.pmw.we) begin
            pmemAddr = q_ff.pmw.addr;
        end else if (q_ff.st == jle_pkg::ST_DATA &&
                     q_ff.cls == jle_pkg::CL_C2) begin
            pmemAddr = q_ff.ptr16;
        end
    end

    assign rfWe      = q_ff.rfw.we;
    assign rfWdata   = q_ff.rfw.wdata;
    assign pmemWe    = q_ff.pmw.we;
    assign pmemWdata = q_ff.pmw.wdata;
    assign pc        = q_ff.pc;
    assign intMask   = q_ff.interrupt_mask_reg;
    assign instrDone = q_ff.done;
    assign illegalOp = q_ff.bad;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_jpcc_exec;
        q_ff.st == jle_pkg::ST_WRITE && q_ff.cls == jle_pkg::CL_JPCC;
    endsequence
    sequence s_jr_exec;
        q_ff.st == jle_pkg::ST_WRITE && q_ff.cls == jle_pkg::CL_JR;
    endsequence

    property p_jp_target;
        s_jpcc_exec ##0 condTrue(q_ff.op[7:4])
            |=> pc == {$past(q_ff.b1), $past(q_ff.b2)};
    endproperty
    a_jp_target: assert property (p_jp_target)
        else $error("taken jump missed its target");

    property p_jump_len;
        s_jpcc_exec ##1 q_ff.taken |-> ##8 instrDone;
    endproperty
    a_jump_len: assert property (p_jump_len)
        else $error("taken jump length wrong");

    property p_ind_jump;
        q_ff.st == jle_pkg::ST_WRITE && q_ff.cls == jle_pkg::CL_JPIND
            |=> pc == $past(q_ff.ptr16) ##3 instrDone;
    endproperty
    a_ind_jump: assert property (p_ind_jump)
        else $error("indirect jump pc or length wrong");

    property p_pair_decode;
        q_ff.st == jle_pkg::ST_PTR && q_ff.cls == jle_pkg::CL_JPIND
            && q_ff.b1[7:4] == jle_pkg::WREG_NIB |-> rfAddr[7:4] == wrkPtr;
    endproperty
    a_pair_decode: assert property (p_pair_decode)
        else $error("working pair not decoded");

    property p_rel;
        s_jr_exec ##0 condTrue(q_ff.op[7:4]) |=> pc == $past(q_ff.pc)
            + {{8{$past(q_ff.b1[7])}}, $past(q_ff.b1)};
    endproperty
    a_rel: assert property (p_rel)
        else $error("relative target wrong");

    property p_one_write;
        rfWe |=> !rfWe [*2];
    endproperty
    a_one_write: assert property (p_one_write)
        else $error("more than one register write");

    property p_ldim;
        q_ff.st == jle_pkg::ST_WRITE && q_ff.cls == jle_pkg::CL_LDIM
            |=> rfWe && rfAddr == {wrkPtr, $past(q_ff.op[7:4])}
                && rfWdata == $past(q_ff.b1);
    endproperty
    a_ldim: assert property (p_ldim)
        else $error("immediate load misdirected");

    property p_imr;
        rfWe && rfAddr == jle_pkg::IMR_ADDR |=> intMask == $past(rfWdata);
    endproperty
    a_imr: assert property (p_imr)
        else $error("mask not updated");

    property p_ldc_store;
        q_ff.st == jle_pkg::ST_WRITE && q_ff.cls == jle_pkg::CL_D2
            |=> pmemWe && !rfWe && pmemAddr == $past(q_ff.ptr16)
                ##6 instrDone;
    endproperty
    a_ldc_store: assert property (p_ldc_store)
        else $error("constant store wrong");
endmodule : jump_load_exec_unit

// *** verif/jle_mem_model.sv ***
// program memory and register file behind the execution slice
// assumes the slice reads combinationally and writes on a rising edge
`timescale 1ns/1ps

module jle_mem_model (
    input  wire logic        ref_clk,
    input  wire logic [15:0] pmemAddr,
    output logic      [7:0]  pmemRdata,
    input  wire logic        pmemWe,
    input  wire logic [7:0]  pmemWdata,
    input  wire logic [7:0]  rfAddr,
    output logic      [7:0]  rfRdata,
    input  wire logic        rfWe,
    input  wire logic [7:0]  rfWdata
);
    logic [7:0] pm [65536];
    logic [7:0] rf [256];

    // unused program space reads as an opcode outside the slice
    initial begin
        foreach (pm[i]) pm[i] = 8'hff;
        foreach (rf[i]) rf[i] = 8'h00;
    end

    // same-cycle read data for the address being driven
    assign pmemRdata = pm[pmemAddr];
    assign rfRdata   = rf[rfAddr];

    // writes land at the edge that samples the strobe
    always @(posedge ref_clk) begin
        if (pmemWe === 1'b1) pm[pmemAddr] <= pmemWdata;
        if (rfWe === 1'b1) rf[rfAddr] <= rfWdata;
    end
endmodule : jle_mem_model

// *** verif/jump_load_exec_unit_test.sv ***
// self-checking bench for the jump/load execution slice
// assumes the memory model is instantiated as mem, working group 1
`timescale 1ns/1ps

module jump_load_exec_unit_test;
    logic            ref_clk = 1'b0;
    logic            rst_b   = 1'b0;
    logic [3:0]      wrkPtr  = 4'h1;
    jle_pkg::flags_s flags   = '0;
    logic [15:0]     pmemAddr;
    logic [7:0]      pmemRdata;
    logic            pmemWe;
    logic [7:0]      pmemWdata;
    logic [7:0]      rfAddr;
    logic [7:0]      rfRdata;
    logic            rfWe;
    logic [7:0]      rfWdata;
    logic [15:0]     pc;
    logic [7:0]      intMask;
    logic            instrDone;
    logic            illegalOp;
    int              error_cnt = 0;
    int              n_checks  = 0;
    logic [15:0]     a;
    logic [15:0]     n;

    always #2 ref_clk = ~ref_clk;

    jump_load_exec_unit DUT (.ref_clk(ref_clk), .rst_b(rst_b),
        .wrkPtr(wrkPtr), .flags(flags), .pmemAddr(pmemAddr),
        .pmemRdata(pmemRdata), .pmemWe(pmemWe), .pmemWdata(pmemWdata),
        .rfAddr(rfAddr), .rfRdata(rfRdata), .rfWe(rfWe),
        .rfWdata(rfWdata), .pc(pc), .intMask(intMask),
        .instrDone(instrDone), .illegalOp(illegalOp));

    jle_mem_model mem (.ref_clk(ref_clk), .pmemAddr(pmemAddr),
        .pmemRdata(pmemRdata), .pmemWe(pmemWe), .pmemWdata(pmemWdata),
        .rfAddr(rfAddr), .rfRdata(rfRdata), .rfWe(rfWe),
        .rfWdata(rfWdata));

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask : check

    // falling edges until the next fetch cycle; a hang ends the run
    task automatic to_fetch(output logic [15:0] cnt);
        cnt = 16'h0;
        do begin
            @(negedge ref_clk);
            cnt++;
            if (cnt > 16'd40) begin
                error_cnt++;
                end_sim;
            end
        end while (instrDone !== 1'b1);
    endtask : to_fetch

    // called in a fetch cycle: place bytes at pc, time the instruction
    task automatic run(input logic [7:0] b0, b1, b2,
                       output logic [15:0] at, output logic [15:0] cnt);
        at = pc;
        mem.pm[at] = b0;
        mem.pm[at + 16'h1] = b1;
        mem.pm[at + 16'h2] = b2;
        to_fetch(cnt);
    endtask : run

    // carry condition taken then not taken
    task automatic t_jump;
        flags.c = 1'b1;
        run(8'h7d, 8'h15, 8'h20, a, n);
        check(n, 16'd12, "jp taken len");
        check(pc, 16'h1520, "jp target");
        flags.c = 1'b0;
        run(8'h7d, 8'h00, 8'h40, a, n);
        check(n, 16'd10, "jp skip len");
        check(pc, a + 16'h3, "jp fall through");
        $display("test jump done");
    endtask : t_jump

    // forward end (+127) of the displacement range, a -45 backward jump, plus never-true
    task automatic t_rel;
        run(8'h8b, 8'hd3, 8'hff, a, n);
        check(n, 16'd12, "jr taken len");
        check(pc, a + 16'h2 - 16'd45, "jr backward");
        run(8'h8b, 8'h7f, 8'hff, a, n);
        check(pc, a + 16'h2 + 16'd127, "jr forward");
        run(8'h0b, 8'h05, 8'hff, a, n);
        check(n, 16'd10, "jr skip len");
        check(pc, a + 16'h2, "jr never");
        $display("test relative done");
    endtask : t_rel

    // pair pointer through working pair 2 of group 1
    task automatic t_ind;
        mem.rf[8'h12] = 8'h3f;
        mem.rf[8'h13] = 8'h45;
        run(8'h30, 8'he2, 8'hff, a, n);
        check(n, 16'd8, "jp ind len");
        check(pc, 16'h3f45, "jp ind target");
        $display("test indirect done");
    endtask : t_ind

    // register forms: direct copy and immediate into working reg
    task automatic t_ld;
        mem.rf[8'h45] = 8'hcf;
        mem.rf[8'hcf] = 8'h5a;
        run(8'he4, 8'h45, 8'h34, a, n);
        check(n, 16'd10, "ld r r len");
        check(mem.rf[8'h34], 8'hcf, "ld dst");
        check(mem.rf[8'h45], 8'hcf, "ld src kept");
        run(8'he5, 8'h45, 8'h36, a, n);
        check(mem.rf[8'h36], 8'h5a, "ld indirect src");
        run(8'hfc, 8'h34, 8'hff, a, n);
        check(n, 16'd6, "ld imm len");
        check(mem.rf[8'h1f], 8'h34, "ld imm dst");
        $display("test load done");
    endtask : t_ld

    // remaining register forms, E-nibble operands, a second group
    task automatic t_forms;
        run(8'he4, 8'he2, 8'h50, a, n);
        check(mem.rf[8'h50], 8'h3f, "ld working src");
        run(8'he4, 8'h50, 8'he5, a, n);
        check(mem.rf[8'h15], 8'h3f, "ld working dst");
        run(8'he6, 8'h60, 8'ha4, a, n);
        check(mem.rf[8'h60], 8'ha4, "ld reg imm");
        mem.rf[8'h1e] = 8'h7f;
        run(8'he7, 8'hee, 8'hfc, a, n);
        check(mem.rf[8'h7f], 8'hfc, "ld ind imm");
        run(8'hf5, 8'h60, 8'h34, a, n);
        check(mem.rf[8'hcf], 8'ha4, "ld ind dst");
        run(8'hf8, 8'h60, 8'hff, a, n);
        check(mem.rf[8'h1f], 8'ha4, "ld r from reg");
        run(8'he9, 8'h61, 8'hff, a, n);
        check(mem.rf[8'h61], 8'h7f, "ld reg from r");
        mem.rf[8'h1c] = 8'h60;
        run(8'he3, 8'hdc, 8'hff, a, n);
        check(mem.rf[8'h1d], 8'ha4, "ld r from ind r");
        run(8'hf3, 8'hdc, 8'hff, a, n);
        check(mem.rf[8'ha4], 8'h60, "ld ind r from r");
        // group change made at the falling edge in the fetch cycle, before any operand read
        wrkPtr = 4'h2;
        run(8'hfc, 8'h5b, 8'hff, a, n);
        check(mem.rf[8'h2f], 8'h5b, "ld imm group 2");
        wrkPtr = 4'h1;
        $display("test forms done");
    endtask : t_forms

    // indexed store into the mask register, then indexed load
    task automatic t_idx;
        mem.rf[8'h10] = 8'h0b;
        mem.rf[8'h1a] = 8'h83;
        run(8'hd7, 8'ha0, 8'hf0, a, n);
        check(mem.rf[8'hfb], 8'h83, "idx store");
        check(intMask, 8'h83, "mask updated");
        mem.rf[8'h10] = 8'h08;
        mem.rf[8'h2c] = 8'h4f;
        run(8'hc7, 8'ha0, 8'h24, a, n);
        check(mem.rf[8'h1a], 8'h4f, "idx load");
        check(mem.rf[8'h10], 8'h08, "index kept");
        $display("test indexed done");
    endtask : t_idx

    // program memory to working reg and back
    task automatic t_const;
        mem.rf[8'h16] = 8'h30;
        mem.rf[8'h17] = 8'ha2;
        mem.pm[16'h30a2] = 8'h22;
        run(8'hc2, 8'h26, 8'hff, a, n);
        check(n, 16'd12, "ldc len");
        check(mem.rf[8'h12], 8'h22, "ldc load");
        check(mem.rf[8'h16], 8'h30, "pair kept");
        mem.rf[8'h12] = 8'h55;
        mem.rf[8'h16] = 8'h10;
        run(8'hd2, 8'h26, 8'hff, a, n);
        check(n, 16'd12, "ldc store len");
        check(mem.pm[16'h10a2], 8'h55, "ldc store");
        check(mem.rf[8'h17], 8'ha2, "pair lo kept");
        $display("test constant done");
    endtask : t_const

    // reset, skip the filler opcode at zero, then the scenarios
    initial begin
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        check(illegalOp, 16'h1, "filler flagged");
        to_fetch(n);
        t_jump;
        t_rel;
        t_ind;
        t_ld;
        t_forms;
        t_idx;
        t_const;
        end_sim;
    end
endmodule : jump_load_exec_unit_test
